// File: hdl/pgpa_pkg.sv
// Constants and carrier types for the password guarded parameter bank
package pgpa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_IN_STAT  = 8'h00;
  localparam logic [7:0] ADDR_OUT_STAT = 8'h04;
  localparam logic [7:0] ADDR_PROGRESS = 8'h08;
  localparam logic [7:0] ADDR_TEST     = 8'h0c;
  localparam logic [7:0] ADDR_PW_OPEN  = 8'h10;
  localparam logic [7:0] ADDR_PW_CLOSE = 8'h14;
  localparam logic [7:0] ADDR_PW_STAT  = 8'h18;
  localparam logic [7:0] ADDR_SETTING  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Password values and limits
  localparam int          PW_W        = 10;
  localparam logic [15:0] PW_MIN      = 16'h0001;
  localparam logic [15:0] PW_MAX      = 16'h03e7;
  localparam logic [9:0]  PW_RESET    = 10'h001;
  localparam logic [9:0]  PW_LOCKED   = 10'h000;
  localparam logic [2:0]  WRONG_LIMIT = 3'h7;

  // Guarded setting, tenths of a second
  localparam logic [15:0] SET_MIN   = 16'h0002;
  localparam logic [15:0] SET_MAX   = 16'h0bb8;
  localparam logic [15:0] SET_RESET = 16'h0032;

  // Reclose progress code limit
  localparam logic [2:0] PROG_MAX = 3'h5;

  // Status and test register field positions
  localparam int PWS_OPEN_BIT   = 0;
  localparam int PWS_LOCK_BIT   = 1;
  localparam int PWS_COUNT_LSB  = 4;
  localparam int TEST_FLAG_LSB  = 1;

  // Interrupt bits
  localparam int IRQ_W        = 3;
  localparam int IRQ_BAD_PW   = 0;
  localparam int IRQ_LOCKOUT  = 1;
  localparam int IRQ_REFUSED  = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic reclose_start_input_4;
    logic reclose_start_input_3;
    logic reclose_start_input_2;
    logic reclose_start_input_1;
    logic remote_reset_input;
    logic block_input_two;
    logic reclose_control_input;
    logic breaker_position_input;
    logic reclose_inhibit_input;
  } pgpa_in_stat_t;

  typedef struct packed {
    logic       breaker_failure_output;
    logic       breaker_open_output;
    logic [3:0] definite_trip_alarm;
    logic [4:0] shot_due;
  } pgpa_out_stat_t;

  typedef struct packed {
    logic breaker_close_output;
    logic start_output_4;
    logic trip_output_3;
    logic start_output_3;
    logic trip_output_2;
    logic start_output_2;
    logic trip_output_1;
    logic start_output_1;
  } pgpa_relay_t;

  typedef struct packed {
    pgpa_relay_t flags;
    logic        relay_test_enable;
  } pgpa_test_t;

  typedef enum logic [1:0] {
    PGPA_CLOSED = 2'b00,
    PGPA_OPEN   = 2'b01,
    PGPA_LOCKED = 2'b10
  } pgpa_pw_state_t;

endpackage

// File: hdl/pgpa_top.sv
// Password guarded parameter bank with relay test and interrupt logic
`timescale 1ns/1ps
`default_nettype none

module pgpa_top (
  input  wire logic                    clk_i,          // 100 MHz clock
  input  wire logic                    rst_i,          // Sync reset, high
  input  wire logic                    wb_cyc_i,       // Bus cycle
  input  wire logic                    wb_stb_i,       // Bus strobe
  input  wire logic                    wb_we_i,        // Write enable
  input  wire logic [7:0]              wb_adr_i,       // Byte address
  input  wire logic [3:0]              wb_sel_i,       // Byte lanes
  input  wire logic [31:0]             wb_dat_i,       // Write data
  output logic      [31:0]             wb_dat_o,       // Read data
  output logic                         wb_ack_o,       // Acknowledge
  input  wire pgpa_pkg::pgpa_in_stat_t  in_stat_i,     // Input flags
  input  wire pgpa_pkg::pgpa_out_stat_t out_stat_i,    // Output flags
  input  wire logic [2:0]              progress_i,     // Shot in progress
  input  wire logic                    supply_fail_i,  // Supply failure
  input  wire logic                    panel_pw_wr_i,  // Panel pw change
  input  wire logic [15:0]             panel_pw_i,     // New panel pw
  input  wire logic                    panel_set_wr_i, // Panel setting
  input  wire logic [15:0]             panel_set_i,    // Setting value
  output pgpa_pkg::pgpa_relay_t         relay_test_o,  // Test drives
  output logic      [15:0]             setting_o,      // Guarded setting
  output logic                         irq_o           // Interrupt level
);
  import pgpa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic           req;
  logic           wr;
  logic           wr_ok;
  logic [15:0]    wval;
  logic           wr_open;
  logic           wr_close;
  logic           wr_set;
  logic           wr_test;
  logic           wr_ro;
  logic           pw_is_open;
  pgpa_pw_state_t pw_state;
  logic [PW_W-1:0] password;
  logic [2:0]     wrong_cnt;
  pgpa_test_t     test_reg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_ev;
  logic [31:0]    rd_data;
  logic [2:0]     prog_code;

  // Range check on a password candidate
  function automatic logic pw_legal(input logic [15:0] v);
    pw_legal = (v >= PW_MIN) && (v <= PW_MAX);
  endfunction

  // Range check on a setting candidate
  function automatic logic set_legal(input logic [15:0] v);
    set_legal = (v >= SET_MIN) && (v <= SET_MAX);
  endfunction

  // One request per bus cycle; writes need the two low lanes
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr         = req && wb_we_i;
  assign wr_ok      = wr && (wb_sel_i[1:0] == 2'b11);
  assign wval       = wb_dat_i[15:0];
  assign wr_open    = wr_ok && (wb_adr_i == ADDR_PW_OPEN);
  assign wr_close   = wr_ok && (wb_adr_i == ADDR_PW_CLOSE);
  assign wr_set     = wr_ok && (wb_adr_i == ADDR_SETTING);
  assign wr_test    = wr_ok && (wb_adr_i == ADDR_TEST);
  assign pw_is_open = (pw_state == PGPA_OPEN);
  // Writes to read-only parameters are rejected
  assign wr_ro      = wr_ok && ((wb_adr_i == ADDR_IN_STAT) ||
                                (wb_adr_i == ADDR_OUT_STAT) ||
                                (wb_adr_i == ADDR_PROGRESS) ||
                                (wb_adr_i == ADDR_PW_STAT) ||
                                (wb_adr_i == ADDR_IRQ_STAT));

  // Progress code outside 1..5 reads as idle
  assign prog_code = (progress_i > PROG_MAX) ? 3'h0 : progress_i;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge, one cycle after the strobe, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data mux
  always_comb begin
    rd_data = 32'h0;
    case (wb_adr_i)
      ADDR_IN_STAT:  rd_data[8:0]  = in_stat_i;
      ADDR_OUT_STAT: rd_data[10:0] = out_stat_i;
      ADDR_PROGRESS: rd_data[2:0]  = prog_code;
      ADDR_TEST:     rd_data[8:0]  = test_reg;
      ADDR_PW_STAT: begin
        rd_data[PWS_OPEN_BIT]        = pw_is_open;
        rd_data[PWS_LOCK_BIT]        = (pw_state == PGPA_LOCKED);
        rd_data[PWS_COUNT_LSB +: 3]  = wrong_cnt;
      end
      ADDR_SETTING:  rd_data[15:0] = setting_o;
      ADDR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_EN:   rd_data[IRQ_W-1:0] = irq_en;
      default:       rd_data = 32'h0;
    endcase
  end

  // Read data register, zero outside a read answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end else begin
      wb_dat_o <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Password state, stored value and wrong attempt count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pw_state  <= PGPA_CLOSED;
      password  <= PW_RESET;
      wrong_cnt <= 3'h0;
    end else if (panel_pw_wr_i && pw_legal(panel_pw_i)) begin
      // Panel value wins; a lockout lifts, supply loss or close still closes
      password  <= panel_pw_i[PW_W-1:0];
      wrong_cnt <= 3'h0;
      if ((pw_state == PGPA_LOCKED) || supply_fail_i || wr_close) begin
        pw_state <= PGPA_CLOSED;
      end
    end else if (supply_fail_i) begin
      if (pw_state == PGPA_OPEN) begin
        pw_state <= PGPA_CLOSED;
      end
    end else if (wr_open && (pw_state != PGPA_LOCKED)) begin
      if (wval == {6'h0, password}) begin
        pw_state  <= PGPA_OPEN;
        wrong_cnt <= 3'h0;
      end else if ((wrong_cnt + 3'h1) == WRONG_LIMIT) begin
        password  <= PW_LOCKED;
        pw_state  <= PGPA_LOCKED;
        wrong_cnt <= 3'h0;
      end else begin
        wrong_cnt <= wrong_cnt + 3'h1;
      end
    end else if (wr_close && (pw_state != PGPA_LOCKED)) begin
      if (pw_is_open && pw_legal(wval)) begin
        password <= wval[PW_W-1:0];
      end
      pw_state <= PGPA_CLOSED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Guarded setting, range checked from both sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setting_o <= SET_RESET;
    end else if (panel_set_wr_i && set_legal(panel_set_i)) begin
      setting_o <= panel_set_i;
    end else if (wr_set && pw_is_open && set_legal(wval)) begin
      setting_o <= wval;
    end
  end

  // Relay test register, protected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_reg <= '0;
    end else if (wr_test && pw_is_open) begin
      test_reg <= wb_dat_i[8:0];
    end
  end

  // Test flags reach the relays only while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_test_o <= '0;
    end else if (test_reg.relay_test_enable) begin
      relay_test_o <= test_reg.flags;
    end else begin
      relay_test_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_BAD_PW]  = wr_open && (pw_state != PGPA_LOCKED) &&
                          !(panel_pw_wr_i && pw_legal(panel_pw_i)) &&
                          !supply_fail_i &&
                          (wval != {6'h0, password});
    irq_ev[IRQ_LOCKOUT] = irq_ev[IRQ_BAD_PW] &&
                          ((wrong_cnt + 3'h1) == WRONG_LIMIT);
    irq_ev[IRQ_REFUSED] = wr_ro ||
                          ((wr_set || wr_test) && !pw_is_open) ||
                          (wr_set && !set_legal(wval)) ||
                          (wr_open && (pw_state == PGPA_LOCKED));
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (wr_ok && (wb_adr_i == ADDR_IRQ_CLR)) begin
      irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en <= IRQ_EN_RESET;
    end else if (wr_ok && (wb_adr_i == ADDR_IRQ_EN)) begin
      irq_en <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Interrupt output level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_bus_quiet;
    !panel_pw_wr_i && !supply_fail_i;
  endsequence

  sequence s_good_open;
    wr_open && (pw_state != PGPA_LOCKED) && (wval == {6'h0, password});
  endsequence

  sequence s_read(logic [7:0] a);
    req && !wb_we_i && (wb_adr_i == a);
  endsequence

  property p_factory_pw;
    $fell(rst_i) |-> (password == PW_RESET) && (pw_state == PGPA_CLOSED);
  endproperty
  a_factory_pw: assert property (p_factory_pw)
    else $error("password not at factory value after reset");

  property p_open_match;
    (s_good_open and s_bus_quiet) |=> pw_is_open && (wrong_cnt == 3'h0);
  endproperty
  a_open_match: assert property (p_open_match)
    else $error("correct password did not open");

  property p_wrong_keeps_closed;
    (wr_open && !pw_is_open && (wval != {6'h0, password})) |=> !pw_is_open;
  endproperty
  a_wrong_keeps_closed: assert property (p_wrong_keeps_closed)
    else $error("wrong password opened access");

  property p_close;
    wr_close |=> !pw_is_open;
  endproperty
  a_close: assert property (p_close)
    else $error("close write left password open");

  property p_supply;
    supply_fail_i |=> !pw_is_open;
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply failure left password open");

  property p_change;
    (wr_close && pw_is_open && pw_legal(wval) && !panel_pw_wr_i &&
     !supply_fail_i) |=> (password == $past(wval[PW_W-1:0]));
  endproperty
  a_change: assert property (p_change)
    else $error("password not changed through close write");

  property p_panel;
    (panel_pw_wr_i && pw_legal(panel_pw_i)) |=>
      (password == $past(panel_pw_i[PW_W-1:0])) && (wrong_cnt == 3'h0);
  endproperty
  a_panel: assert property (p_panel)
    else $error("panel password not stored");

  property p_lockout;
    (wr_open && !panel_pw_wr_i && !supply_fail_i && !pw_is_open &&
     (pw_state != PGPA_LOCKED) && (wval != {6'h0, password}) &&
     (wrong_cnt == 3'h6)) |=> (pw_state == PGPA_LOCKED) &&
     (password == PW_LOCKED) ##1 irq_stat[IRQ_LOCKOUT];
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("seventh wrong attempt did not lock out");

  property p_locked_stays;
    ((pw_state == PGPA_LOCKED) && !panel_pw_wr_i) |=>
      (pw_state == PGPA_LOCKED) && (password == PW_LOCKED);
  endproperty
  a_locked_stays: assert property (p_locked_stays)
    else $error("lockout left without panel change");

  property p_ro_refused;
    wr_ro |=> irq_stat[IRQ_REFUSED];
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("read-only write not flagged");

  property p_protected;
    (wr_set && !pw_is_open && !panel_pw_wr_i && !panel_set_wr_i) |=>
      $stable(setting_o);
  endproperty
  a_protected: assert property (p_protected)
    else $error("protected setting written while closed");

  property p_setting_range;
    set_legal(setting_o);
  endproperty
  a_setting_range: assert property (p_setting_range)
    else $error("setting outside legal range");

  property p_read_inputs;
    s_read(ADDR_IN_STAT) |=>
      (wb_dat_o == {23'h0, $past(in_stat_i)}) && wb_ack_o;
  endproperty
  a_read_inputs: assert property (p_read_inputs)
    else $error("input flags read wrong");

  property p_read_outputs;
    s_read(ADDR_OUT_STAT) |=> (wb_dat_o == {21'h0, $past(out_stat_i)});
  endproperty
  a_read_outputs: assert property (p_read_outputs)
    else $error("output flags read wrong");

  property p_progress;
    s_read(ADDR_PROGRESS) |=> (wb_dat_o[31:3] == 29'h0) &&
      (wb_dat_o[2:0] == (($past(progress_i) <= PROG_MAX) ?
                         $past(progress_i) : 3'h0));
  endproperty
  a_progress: assert property (p_progress)
    else $error("progress code out of range");

  property p_relay_gate;
    !test_reg.relay_test_enable |=> (relay_test_o == '0);
  endproperty
  a_relay_gate: assert property (p_relay_gate)
    else $error("relay driven while test disabled");

  property p_close_relay;
    (test_reg.relay_test_enable && test_reg.flags.breaker_close_output) |=>
      relay_test_o.breaker_close_output;
  endproperty
  a_close_relay: assert property (p_close_relay)
    else $error("breaker close test flag not driven");

endmodule // pgpa_top

`default_nettype wire

// File: dv/pgpa_bus_master.sv
// Bus master station model that reads and writes parameters
`timescale 1ns/1ps
`default_nettype none

module pgpa_bus_master (
  input  wire logic        clk_i,  // Bus clock
  input  wire logic        ack_i,  // Slave acknowledge
  input  wire logic [31:0] rdat_i, // Slave read data
  output logic             cyc_o,  // Cycle
  output logic             stb_o,  // Strobe
  output logic             we_o,   // Write enable
  output logic [7:0]       adr_o,  // Byte address
  output logic [3:0]       sel_o,  // Byte lanes
  output logic [31:0]      wdat_o  // Write data
);
  // Idle bus at time zero
  initial begin
    cyc_o  = 1'b0;
    stb_o  = 1'b0;
    we_o   = 1'b0;
    adr_o  = 8'h00;
    sel_o  = 4'h0;
    wdat_o = 32'h0;
  end

  // One classic cycle, request held until ack is sampled high
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o  <= 1'b1;
    stb_o  <= 1'b1;
    we_o   <= w;
    adr_o  <= a;
    sel_o  <= 4'hf;
    wdat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = rdat_i;
    cyc_o  <= 1'b0;
    stb_o  <= 1'b0;
    we_o   <= 1'b0;
    wdat_o <= ~d; // Released data does not keep its value
  endtask
endmodule // pgpa_bus_master

`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the password guarded parameter bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pgpa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic           clk_i        = 1'b0;
  logic           rst_i        = 1'b1;
  logic           cyc, stb, we, ack;
  logic [7:0]     adr;
  logic [3:0]     sel;
  logic [31:0]    wdat, rdat, rd;
  pgpa_in_stat_t  in_stat      = '0;
  pgpa_out_stat_t out_stat     = '0;
  logic [2:0]     progress     = 3'h0;
  logic           supply_fail  = 1'b0;
  logic           panel_pw_wr  = 1'b0;
  logic           panel_set_wr = 1'b0;
  logic [15:0]    panel_pw     = 16'h0;
  logic [15:0]    panel_set    = 16'h0;
  pgpa_relay_t    relay_test;
  logic [15:0]    setting;
  logic           irq;
  int             failures        = 0;
  int             samples_checked = 0;
  int             cycles          = 0;

  // Clock, 10 ns period
  always #5 clk_i = ~clk_i;

  pgpa_bus_master i_pgpa_bus_master (.clk_i(clk_i), .ack_i(ack),
    .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .wdat_o(wdat));

  pgpa_top i_pgpa_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .in_stat_i(in_stat),
    .out_stat_i(out_stat), .progress_i(progress),
    .supply_fail_i(supply_fail), .panel_pw_wr_i(panel_pw_wr),
    .panel_pw_i(panel_pw), .panel_set_wr_i(panel_set_wr),
    .panel_set_i(panel_set), .relay_test_o(relay_test),
    .setting_o(setting), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_pgpa_bus_master.access(1'b1, a, d, rd);
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    i_pgpa_bus_master.access(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask

  // Front panel entry: password when pw is set, else setting
  task automatic panel(input logic pw, input logic [15:0] v);
    @(posedge clk_i);
    panel_pw_wr  <= pw;
    panel_set_wr <= ~pw;
    panel_pw     <= v;
    panel_set    <= v;
    @(posedge clk_i);
    panel_pw_wr  <= 1'b0;
    panel_set_wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("setting_o", 32'h32, {16'h0, setting});
    chk("relay_test_o", 32'h0, {24'h0, relay_test});
    rchk("pw status", ADDR_PW_STAT, 32'h0);
    wr(ADDR_PW_OPEN, 32'h1);
    rchk("pw factory", ADDR_PW_STAT, 32'h1);
    wr(ADDR_PW_CLOSE, 32'h0);
    rchk("pw closed", ADDR_PW_STAT, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_flags();
    in_stat  <= pgpa_in_stat_t'(9'h155);
    out_stat <= pgpa_out_stat_t'(11'h6a5);
    for (int p = 0; p < 8; p++) begin
      progress <= 3'(p);
      rchk("progress", ADDR_PROGRESS, (p <= 5) ? 32'(p) : 32'h0);
    end
    rchk("in flags", ADDR_IN_STAT, 32'h155);
    rchk("out flags", ADDR_OUT_STAT, 32'h6a5);
    in_stat  <= pgpa_in_stat_t'(9'h0aa);
    out_stat <= pgpa_out_stat_t'(11'h15a);
    wr(ADDR_IN_STAT, 32'h0);
    rchk("in flags ro", ADDR_IN_STAT, 32'h0aa);
    rchk("out flags 2", ADDR_OUT_STAT, 32'h15a);
    rchk("unmapped", 8'h30, 32'h0);
    $display("test flags done");
  endtask

  task automatic t_setting();
    wr(ADDR_IRQ_CLR, 32'h7);
    wr(ADDR_SETTING, 32'h100);
    chk("setting closed", 32'h32, {16'h0, setting});
    rchk("refused irq", ADDR_IRQ_STAT, 32'h4);
    wr(ADDR_PW_OPEN, 32'h1);
    wr(ADDR_SETTING, 32'hbb8);
    chk("setting max", 32'hbb8, {16'h0, setting});
    wr(ADDR_SETTING, 32'hbb9);
    wr(ADDR_SETTING, 32'h1);
    rchk("setting kept", ADDR_SETTING, 32'hbb8);
    panel(1'b0, 16'h1);
    chk("panel bad", 32'hbb8, {16'h0, setting});
    panel(1'b0, 16'h2);
    chk("panel min", 32'h2, {16'h0, setting});
    $display("test setting done");
  endtask

  task automatic t_relay();
    wr(ADDR_TEST, 32'h154);
    settle();
    chk("relay off", 32'h0, {24'h0, relay_test});
    rchk("test rb", ADDR_TEST, 32'h154);
    wr(ADDR_TEST, 32'h155);
    settle();
    chk("relay on", 32'haa, {24'h0, relay_test});
    wr(ADDR_TEST, 32'h101);
    settle();
    chk("close drive", 32'h80, {24'h0, relay_test});
    wr(ADDR_PW_CLOSE, 32'h0);
    wr(ADDR_TEST, 32'h0);
    settle();
    chk("test guarded", 32'h80, {24'h0, relay_test});
    wr(ADDR_PW_OPEN, 32'h1);
    wr(ADDR_TEST, 32'h0);
    $display("test relay done");
  endtask

  task automatic t_password();
    wr(ADDR_PW_CLOSE, 32'h3e7);
    rchk("closed", ADDR_PW_STAT, 32'h0);
    wr(ADDR_PW_OPEN, 32'h1);
    rchk("old pw wrong", ADDR_PW_STAT, 32'h10);
    wr(ADDR_PW_OPEN, 32'h3e7);
    rchk("count cleared", ADDR_PW_STAT, 32'h1);
    supply_fail <= 1'b1;
    settle();
    supply_fail <= 1'b0;
    rchk("supply fail", ADDR_PW_STAT, 32'h0);
    $display("test password done");
  endtask

  task automatic t_lockout();
    wr(ADDR_IRQ_CLR, 32'h7);
    wr(ADDR_IRQ_EN, 32'h0);
    for (int i = 0; i < 6; i++)
      wr(ADDR_PW_OPEN, 32'h2);
    rchk("six wrong", ADDR_PW_STAT, 32'h60);
    wr(ADDR_PW_OPEN, 32'h2);
    rchk("locked", ADDR_PW_STAT, 32'h2);
    rchk("irq stat", ADDR_IRQ_STAT, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_EN, 32'h2);
    settle();
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_CLR, 32'h2);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_PW_OPEN, 32'h0);
    wr(ADDR_PW_OPEN, 32'h3e7);
    wr(ADDR_PW_CLOSE, 32'h5);
    rchk("still locked", ADDR_PW_STAT, 32'h2);
    panel(1'b1, 16'h42);
    rchk("unlocked", ADDR_PW_STAT, 32'h0);
    wr(ADDR_PW_OPEN, 32'h42);
    rchk("panel pw", ADDR_PW_STAT, 32'h1);
    $display("test lockout done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_flags();
    t_setting();
    t_relay();
    t_password();
    t_lockout();
    results();
  end
endmodule // tb

`default_nettype wire
